// ===== rtl/sbm_pkg.sv
// Package: commands, mode layout, timing and register map of the SDRAM burst pair.
package sbm_pkg;
  // ******************************************
  // Commands on the link
  // ******************************************
  typedef enum logic [2:0] {
    SBM_NOP,
    SBM_ACT,
    SBM_RD,
    SBM_WR,
    SBM_BST,
    SBM_PRE,
    SBM_LMR
  } sbm_cmd_t;

  // ******************************************
  // Mode register layout
  // ******************************************
  localparam int ADDR_W = 13;
  localparam int BANK_N = 4;
  localparam int MODE_W = 10;
  localparam int LEN_LSB = 0;
  localparam int LEN_W = 3;
  localparam int BT_BIT = 3;
  localparam int RL_LSB = 4;
  localparam int RL_W = 3;
  localparam int OPM_LSB = 7;
  localparam int OPM_W = 2;
  localparam int SWB_BIT = 9;
  localparam int X4_COL_W = 11;
  localparam logic [2:0] LEN_1 = 3'h0;
  localparam logic [2:0] LEN_2 = 3'h1;
  localparam logic [2:0] LEN_4 = 3'h2;
  localparam logic [2:0] LEN_8 = 3'h3;
  localparam logic [2:0] LEN_PAGE = 3'h7;
  localparam logic [2:0] RL_2 = 3'h2;
  localparam logic [2:0] RL_3 = 3'h3;
  localparam logic [MODE_W-1:0] MODE_RST = 10'h020;

  // ******************************************
  // Timing
  // ******************************************
  localparam int CLK_PERIOD_NS = 25;
  localparam int ACTIVATE_TO_ACCESS_DELAY_NS = 20;
  localparam int SAME_BANK_ACTIVATE_INTERVAL_NS = 66;
  localparam int CROSS_BANK_ACTIVATE_INTERVAL_NS = 15;
  localparam int MODE_LOAD_SETTLE_DELAY_NS = 30;
  localparam int TMR_W = 4;

  function automatic logic [TMR_W-1:0] sbm_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    if (c < 1) c = 1;
    return TMR_W'(c);
  endfunction

  localparam logic [TMR_W-1:0] ACC_CYC = sbm_cyc(ACTIVATE_TO_ACCESS_DELAY_NS);
  localparam logic [TMR_W-1:0] SAME_CYC = sbm_cyc(SAME_BANK_ACTIVATE_INTERVAL_NS);
  localparam logic [TMR_W-1:0] CROSS_CYC = sbm_cyc(CROSS_BANK_ACTIVATE_INTERVAL_NS);
  localparam logic [TMR_W-1:0] SETTLE_CYC = sbm_cyc(MODE_LOAD_SETTLE_DELAY_NS);

  // ******************************************
  // Controller registers
  // ******************************************
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_WDATA = 8'h04;
  localparam logic [7:0] REG_RDATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam int CMD_BANK_LSB = 16;
  localparam int CMD_OP_LSB = 20;
  localparam int ST_BUSY = 0;
  localparam int ST_REFUSED = 1;
  localparam int ST_CNT_LSB = 8;
  localparam int CNT_W = 8;
  localparam logic [2:0] WORD_SIZE = 3'h2;
endpackage

// ===== rtl/sbm_if.sv
// Interface: command, address and shared data pins between controller and device.
`timescale 1ns/1ps
`default_nettype none
interface sbm_if
  import sbm_pkg::*;
#(
  parameter int DQ_W = 8
);
  sbm_cmd_t          cmd;
  logic [1:0]        bank;
  logic [ADDR_W-1:0] addr;
  logic [DQ_W-1:0]   dq_c;
  logic              dq_c_oe;
  logic [DQ_W-1:0]   dq_d;
  logic              dq_d_oe;
  logic [DQ_W-1:0]   dq;

  // Resolved data wire; an undriven wire reads as zero.
  assign dq = dq_d_oe ? dq_d : (dq_c_oe ? dq_c : '0);

  modport dev (input cmd, bank, addr, dq, output dq_d, dq_d_oe);
  modport ctl (output cmd, bank, addr, dq_c, dq_c_oe, input dq, dq_d_oe);
endinterface
`default_nettype wire

// ===== rtl/sbm_sdram_dev.sv
// Device end: mode register, row activation, burst column order and read latency.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Burst lengths one, two, four, eight, page.
// - Page burst sequential only; terminate ends it.
// - Burst stays in aligned block, wraps inside.
// - Page burst wraps round the open row.
// - Order bit picks sequential or interleaved.
// - Sequential adds offset; interleaved XORs offset.
// - Burst of one: all bits, order ignored.
// - Page width follows organisation column bits.
// - Controller never programs reserved burst lengths.
// - Read latency two or three clocks.
// - Drive from edge n+m-1, valid n+m.
// - Controller keeps operating mode bits zero.
// - Single write bit makes writes one location.
// - Controller activates row before read/write.
// - Controller waits activate-to-access delay, rounded up.
// - Same bank reactivation: precharge, interval apart.
// - Cross bank activates kept interval apart.
// - Mode fields: length, order, latency, op, write.
// - Mode load only idle, then settle delay.
module sbm_sdram_dev
  import sbm_pkg::*;
#(
  parameter int COL_W = 10,
  parameter int ROW_W = 4,
  parameter int DQ_W  = 8
) (
  input  wire logic              mclk,
  input  wire logic              srst,
  sbm_if.dev                     bus,
  output logic [MODE_W-1:0]      mode,
  output logic [BANK_N-1:0]      bank_open,
  output logic                   burst_busy,
  output logic                   mode_reserved
);
  localparam int AW = 2 + ROW_W + COL_W;

  // ******************************************
  // State
  // ******************************************
  typedef struct packed {
    logic [MODE_W-1:0]            mode;
    logic                         rsv;
    logic [BANK_N-1:0]            open;
    logic [BANK_N-1:0][ROW_W-1:0] row;
    logic                         act;
    logic                         rd;
    logic [1:0]                   bk;
    logic [COL_W-1:0]             start;
    logic [COL_W-1:0]             cnt;
    logic [COL_W-1:0]             mask;
    logic                         page;
    logic                         ilv;
    logic [1:0]                   pv;
    logic [1:0][AW-1:0]           pa;
    logic [DQ_W-1:0]              dq;
    logic                         oe;
  } sbm_dev_st_t;

  sbm_dev_st_t      s;
  sbm_dev_st_t      next_s;
  logic [DQ_W-1:0]  mem [0:(2**AW)-1];
  logic [COL_W-1:0] col_in;
  logic [COL_W-1:0] ofs;
  logic [COL_W-1:0] col;
  logic [AW-1:0]    ea;
  logic             wr_en;
  logic             lat2;
  logic [LEN_W-1:0] blc;
  logic [RL_W-1:0]  rlc;

  // ******************************************
  // Column address pins
  // ******************************************
  // The by-four part skips the auto-precharge bit A10 in its column.
  generate
    if (COL_W == X4_COL_W) begin : g_x4
      assign col_in = {bus.addr[X4_COL_W], bus.addr[X4_COL_W-2:0]};
    end else begin : g_nx4
      assign col_in = bus.addr[COL_W-1:0];
    end
  endgenerate

  // ******************************************
  // Next state
  // ******************************************
  always_comb begin
    next_s = s;
    wr_en  = 1'b0;
    blc    = s.mode[LEN_LSB +: LEN_W];
    rlc    = s.mode[RL_LSB +: RL_W];

    unique case (bus.cmd)
      SBM_LMR: begin
        next_s.mode = bus.addr[MODE_W-1:0];
      end
      SBM_ACT: begin
        next_s.open[bus.bank] = 1'b1;
        next_s.row[bus.bank]  = bus.addr[ROW_W-1:0];
      end
      SBM_PRE: begin
        next_s.open[bus.bank] = 1'b0;
      end
      SBM_BST: begin
        next_s.act = 1'b0;
      end
      SBM_RD, SBM_WR: begin
        next_s.act   = 1'b1;
        next_s.rd    = (bus.cmd == SBM_RD);
        next_s.bk    = bus.bank;
        next_s.start = col_in;
        next_s.cnt   = '0;
        next_s.ilv   = s.mode[BT_BIT];
        next_s.page  = 1'b0;
        next_s.mask  = '0;
        unique case (blc)
          LEN_2, LEN_4, LEN_8: begin
            next_s.mask = COL_W'((1 << blc) - 1);
          end
          LEN_PAGE: begin
            next_s.page = !s.mode[BT_BIT];
          end
          default: begin
            next_s.mask = '0;
          end
        endcase
        if (bus.cmd == SBM_WR && s.mode[SWB_BIT]) begin
          next_s.mask = '0;
          next_s.page = 1'b0;
        end
      end
      default: begin
      end
    endcase

    next_s.rsv = !(next_s.mode[LEN_LSB +: LEN_W] inside {LEN_1, LEN_2, LEN_4, LEN_8}
                   || (next_s.mode[LEN_LSB +: LEN_W] == LEN_PAGE && !next_s.mode[BT_BIT]))
                 || !(next_s.mode[RL_LSB +: RL_W] inside {RL_2, RL_3})
                 || (next_s.mode[OPM_LSB +: OPM_W] != '0);

    // Column of the element taken at this edge.
    if (next_s.ilv) begin
      ofs = next_s.start ^ next_s.cnt;
    end else begin
      ofs = COL_W'(next_s.start + next_s.cnt);
    end
    if (next_s.page) begin
      col = COL_W'(next_s.start + next_s.cnt);
    end else begin
      col = (next_s.start & ~next_s.mask) | (ofs & next_s.mask);
    end
    ea = {next_s.bk, next_s.row[next_s.bk], col};

    // Read pipeline; a write command silences read data still in flight.
    next_s.pv[1] = s.pv[0];
    next_s.pa[1] = s.pa[0];
    next_s.pv[0] = 1'b0;
    next_s.pa[0] = ea;
    if (bus.cmd == SBM_WR) begin
      next_s.pv = '0;
    end
    if (next_s.act) begin
      if (next_s.rd) begin
        next_s.pv[0] = 1'b1;
      end else begin
        wr_en = 1'b1;
      end
      if (!next_s.page && next_s.cnt == next_s.mask) begin
        next_s.act = 1'b0;
      end else begin
        next_s.cnt = COL_W'(next_s.cnt + 1'b1);
      end
    end

    // Output stage loads one edge before the data must be valid.
    lat2      = (rlc == RL_2);
    next_s.oe = (lat2 ? s.pv[0] : s.pv[1]) && (bus.cmd != SBM_WR);
    next_s.dq = mem[lat2 ? s.pa[0] : s.pa[1]];
  end

  // ******************************************
  // Registers
  // ******************************************
  always_ff @(posedge mclk) begin
    if (srst) begin
      s      <= '0;
      s.mode <= MODE_RST;
    end else begin
      s <= next_s;
    end
  end

  // The array has no reset; its content is undefined until written.
  always_ff @(posedge mclk) begin
    if (wr_en && !srst) begin
      mem[ea] <= bus.dq;
    end
  end

  // ******************************************
  // Outputs
  // ******************************************
  assign bus.dq_d      = s.dq;
  assign bus.dq_d_oe   = s.oe;
  assign mode          = s.mode;
  assign bank_open     = s.open;
  assign burst_busy    = s.act;
  assign mode_reserved = s.rsv;
endmodule  // sbm_sdram_dev
`default_nettype wire

// ===== rtl/sbm_sdram_ctl.sv
// Controller end: AHB-Lite registers, command timing checks and data pins.
//
// Our own choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module sbm_sdram_ctl
  import sbm_pkg::*;
#(
  parameter int DQ_W = 8
) (
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  sbm_if.ctl               bus
);
  typedef struct packed {
    logic                         wp;
    logic [7:0]                   wa;
    logic [31:0]                  rd_bus;
    logic                         pend;
    sbm_cmd_t                     pcmd;
    logic [1:0]                   pbank;
    logic [ADDR_W-1:0]            paddr;
    logic [DQ_W-1:0]              wdata;
    logic [DQ_W-1:0]              rdata;
    logic [CNT_W-1:0]             rcnt;
    logic                         refused;
    logic [MODE_W-1:0]            mode;
    logic [BANK_N-1:0]            open;
    logic [BANK_N-1:0][TMR_W-1:0] t_acc;
    logic [BANK_N-1:0][TMR_W-1:0] t_same;
    logic [TMR_W-1:0]             t_cross;
    logic [TMR_W-1:0]             t_mode;
    logic [3:0]                   wleft;
    logic                         wpage;
    sbm_cmd_t                     cmd;
    logic [1:0]                   bank;
    logic [ADDR_W-1:0]            addr;
    logic                         oe;
  } sbm_ctl_st_t;

  sbm_ctl_st_t      s;
  sbm_ctl_st_t      next_s;
  logic [LEN_W-1:0] lc;
  logic [RL_W-1:0]  rl;
  logic             bad;
  logic [1:0]       b;

  // ******************************************
  // Next state
  // ******************************************
  always_comb begin
    next_s = s;
    b      = s.pbank;
    lc     = s.paddr[LEN_LSB +: LEN_W];
    rl     = s.paddr[RL_LSB +: RL_W];
    bad    = !(lc inside {LEN_1, LEN_2, LEN_4, LEN_8} || (lc == LEN_PAGE && !s.paddr[BT_BIT]))
             || !(rl inside {RL_2, RL_3}) || (s.paddr[OPM_LSB +: OPM_W] != '0);
    for (int i = 0; i < BANK_N; i++) begin
      if (s.t_acc[i] != '0) next_s.t_acc[i] = s.t_acc[i] - 1'b1;
      if (s.t_same[i] != '0) next_s.t_same[i] = s.t_same[i] - 1'b1;
    end
    if (s.t_cross != '0) next_s.t_cross = s.t_cross - 1'b1;
    if (s.t_mode != '0) next_s.t_mode = s.t_mode - 1'b1;

    // Bus address phase; read data is registered for the data phase.
    next_s.wp = 1'b0;
    if (hsel && htrans[1] && hready) begin
      next_s.wp = hwrite && (hsize == WORD_SIZE);
      next_s.wa = haddr[7:0];
      case (haddr[7:0])
        REG_WDATA:  next_s.rd_bus = 32'(s.wdata);
        REG_RDATA:  next_s.rd_bus = 32'(s.rdata);
        REG_STATUS: next_s.rd_bus = (32'(s.rcnt) << ST_CNT_LSB)
                                    | (32'(s.refused) << ST_REFUSED) | 32'(s.pend);
        default:    next_s.rd_bus = '0;
      endcase
    end

    // Bus data phase. A command written while one is pending is dropped.
    if (s.wp) begin
      case (s.wa)
        REG_CMD: if (!s.pend) begin
          next_s.pend  = 1'b1;
          next_s.pcmd  = sbm_cmd_t'(hwdata[CMD_OP_LSB +: 3]);
          next_s.pbank = hwdata[CMD_BANK_LSB +: 2];
          next_s.paddr = hwdata[ADDR_W-1:0];
        end
        REG_WDATA:  next_s.wdata = hwdata[DQ_W-1:0];
        REG_STATUS: if (hwdata[ST_REFUSED]) next_s.refused = 1'b0;
        default: begin
        end
      endcase
    end

    if (bus.dq_d_oe) begin
      next_s.rdata = bus.dq;
      next_s.rcnt  = s.rcnt + 1'b1;
    end

    // Write data is driven for as many beats as the burst holds.
    next_s.cmd = SBM_NOP;
    if (s.oe && (s.wpage || s.wleft != '0)) begin
      if (!s.wpage) next_s.wleft = s.wleft - 1'b1;
    end else begin
      next_s.oe = 1'b0;
    end

    if (s.pend && s.t_mode == '0) begin
      next_s.pend = 1'b0;
      unique case (s.pcmd)
        SBM_ACT: begin
          if (s.open[b]) begin
            next_s.refused = 1'b1;
          end else if (s.t_same[b] != '0 || s.t_cross != '0) begin
            next_s.pend = 1'b1;
          end else begin
            next_s.cmd       = SBM_ACT;
            next_s.open[b]   = 1'b1;
            next_s.t_acc[b]  = ACC_CYC - 1'b1;
            next_s.t_same[b] = SAME_CYC - 1'b1;
            next_s.t_cross   = CROSS_CYC - 1'b1;
          end
        end
        SBM_RD, SBM_WR: begin
          if (!s.open[b]) begin
            next_s.refused = 1'b1;
          end else if (s.t_acc[b] != '0) begin
            next_s.pend = 1'b1;
          end else begin
            next_s.cmd   = s.pcmd;
            next_s.oe    = (s.pcmd == SBM_WR);
            next_s.wpage = (s.mode[LEN_LSB +: LEN_W] == LEN_PAGE) && !s.mode[SWB_BIT];
            next_s.wleft = s.mode[SWB_BIT] ? 4'h0
                           : 4'((1 << s.mode[LEN_LSB +: LEN_W]) - 1);
          end
        end
        SBM_LMR: begin
          if (s.open != '0 || bad) begin
            next_s.refused = 1'b1;
          end else begin
            next_s.cmd    = SBM_LMR;
            next_s.mode   = s.paddr[MODE_W-1:0];
            next_s.t_mode = SETTLE_CYC - 1'b1;
          end
        end
        default: begin
          next_s.cmd = s.pcmd;
          next_s.oe  = 1'b0;
          if (s.pcmd == SBM_PRE) next_s.open[b] = 1'b0;
        end
      endcase
      next_s.bank = b;
      next_s.addr = s.paddr;
    end
  end

  // ******************************************
  // Registers
  // ******************************************
  always_ff @(posedge mclk) begin
    if (srst) begin
      s      <= '0;
      s.mode <= MODE_RST;
    end else begin
      s <= next_s;
    end
  end

  // Zero wait states, so the bus never stalls on this slave.
  assign hreadyout   = 1'b1;
  assign hresp       = 1'b0;
  assign hrdata      = s.rd_bus;
  assign bus.cmd     = s.cmd;
  assign bus.bank    = s.bank;
  assign bus.addr    = s.addr;
  assign bus.dq_c    = s.wdata;
  assign bus.dq_c_oe = s.oe;
endmodule  // sbm_sdram_ctl
`default_nettype wire

// ===== tb/sbm_props.sv
// Checker: link timing and command legality between controller and device.
`timescale 1ns/1ps
`default_nettype none
module sbm_props
  import sbm_pkg::*;
(
  input wire logic              mclk,
  input wire logic              srst,
  input wire sbm_cmd_t          cmd,
  input wire logic [1:0]        bank,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic              dq_c_oe,
  input wire logic              dq_d_oe
);
  // ******************************************
  // Shadow of mode and open banks
  // ******************************************
  // Only issued commands reach the wire, so the shadow tracks what the device saw.
  logic [MODE_W-1:0] mode_sh;
  logic [BANK_N-1:0] open_sh;
  logic              lat2;
  assign lat2 = mode_sh[RL_LSB+:RL_W] == RL_2;
  always_ff @(posedge mclk) begin
    if (srst) begin
      mode_sh <= MODE_RST;
      open_sh <= '0;
    end else begin
      if (cmd == SBM_LMR)
        mode_sh <= addr[MODE_W-1:0];
      if (cmd == SBM_ACT)
        open_sh[bank] <= 1'b1;
      if (cmd == SBM_PRE)
        open_sh[bank] <= 1'b0;
    end
  end

  // ******************************************
  // Properties
  // ******************************************
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  sequence quiet; cmd == SBM_NOP; endsequence
  sequence rd2; cmd == SBM_RD && lat2; endsequence
  sequence rd3; cmd == SBM_RD && !lat2; endsequence
  sequence rd3_fresh; cmd == SBM_RD && !lat2 && !dq_d_oe; endsequence
  sequence rd4_fresh;
    cmd == SBM_RD && lat2 && !dq_d_oe && mode_sh[LEN_LSB+:LEN_W] == LEN_4;
  endsequence

  a_latency_two: assert property (rd2 ##1 quiet |=> dq_d_oe)
    else $error("read data not driven two clocks after read");
  a_latency_three: assert property (rd3 ##1 quiet ##1 quiet |=> dq_d_oe)
    else $error("read data not driven three clocks after read");
  a_no_early_drive: assert property (rd3_fresh ##1 (quiet and !dq_d_oe) |=> !dq_d_oe)
    else $error("data pins driven before latency minus one");
  a_burst_four: assert property (rd4_fresh ##1 quiet[*5] |-> dq_d_oe ##1 !dq_d_oe)
    else $error("burst of four has wrong beat count");
  a_same_bank_gap: assert property (cmd == SBM_ACT |=>
      !(cmd == SBM_ACT && bank == $past(bank)) ##1 !(cmd == SBM_ACT && bank == $past(bank, 2)))
    else $error("same bank activates too close");
  a_mode_settle: assert property (cmd == SBM_LMR |=> quiet)
    else $error("command issued inside mode settle time");
  a_idle_load: assert property (cmd == SBM_LMR |-> open_sh == '0)
    else $error("mode loaded with a bank open");
  a_open_first: assert property ((cmd == SBM_RD || cmd == SBM_WR) |-> open_sh[bank])
    else $error("access to a closed bank");
  a_closed_act: assert property (cmd == SBM_ACT |-> !open_sh[bank])
    else $error("activate to a bank already open");
  a_single_write: assert property ((cmd == SBM_WR && mode_sh[SWB_BIT]) |->
      dq_c_oe ##1 !dq_c_oe)
    else $error("write burst longer than one in single write mode");
endmodule // sbm_props
`default_nettype wire

// ===== tb/sdram_burst_mode_and_activation_bench.sv
// Testbench: drives the controller over AHB-Lite and checks bursts seen on the link.
`timescale 1ns/1ps
`default_nettype none
module sdram_burst_mode_and_activation_bench;
  import sbm_pkg::*;
  logic        mclk = 1'b0;
  logic        srst;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  logic [MODE_W-1:0] mode;
  logic [BANK_N-1:0] bank_open;
  logic        burst_busy;
  logic        mode_reserved;
  logic [7:0]  beats[$];
  int          error_cnt = 0;
  int          comparisons = 0;

  sbm_if #(.DQ_W(8)) link ();
  sbm_sdram_dev #(.COL_W(10), .ROW_W(4), .DQ_W(8)) sbm_sdram_dev_inst (.mclk(mclk),
    .srst(srst), .bus(link), .mode(mode), .bank_open(bank_open), .burst_busy(burst_busy),
    .mode_reserved(mode_reserved));
  sbm_sdram_ctl #(.DQ_W(8)) sbm_sdram_ctl_inst (.mclk(mclk), .srst(srst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .bus(link));
  sbm_props sbm_props_inst (.mclk(mclk), .srst(srst), .cmd(link.cmd), .bank(link.bank),
    .addr(link.addr), .dq_c_oe(link.dq_c_oe), .dq_d_oe(link.dq_d_oe));

  always #12.5 mclk = ~mclk;
  always @(posedge mclk) begin
    if (link.dq_d_oe === 1'b1)
      beats.push_back(link.dq);
  end

  // ******************************************
  // Tasks
  // ******************************************
  task automatic summarize();
    if (error_cnt == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // Waits on busy so a command is never dropped by an early second write.
  task automatic op(input sbm_cmd_t c, input logic [1:0] b, input logic [12:0] a);
    logic [31:0] r;
    ahb(1'b1, REG_CMD, {9'h0, c, 2'h0, b, 3'h0, a}, r);
    do ahb(1'b0, REG_STATUS, 32'h0, r); while (r[ST_BUSY] !== 1'b0);
  endtask
  task automatic refused(input string nm);
    logic [31:0] r;
    ahb(1'b0, REG_STATUS, 32'h0, r);
    chk(nm, 32'h1, 32'(r[ST_REFUSED]));
    ahb(1'b1, REG_STATUS, 32'h2, r);
  endtask
  function automatic logic [7:0] dat(input int c);
    return 8'(c + 32'h30);
  endfunction
  task automatic set_mode(input logic [9:0] md);
    op(SBM_PRE, 2'h0, 13'h0);
    op(SBM_LMR, 2'h0, {3'h0, md});
    chk("mode", 32'(md), 32'(mode));
    op(SBM_ACT, 2'h0, 13'h1);
  endtask
  task automatic burst(input logic [9:0] md, input int s, input int n);
    int col;
    set_mode(md);
    beats.delete();
    op(SBM_RD, 2'h0, 13'(s));
    repeat (16) @(posedge mclk);
    chk("beat count", n, beats.size());
    for (int i = 0; i < n; i++) begin
      col = (md[BT_BIT] && n > 1) ? (s ^ i) % n : (s + i) % n;
      col = col + s - s % n;
      chk("beat data", 32'(dat(col)), 32'(beats[i]));
    end
  endtask

  // ******************************************
  // Tests
  // ******************************************
  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    summarize();
  end
  initial begin
    logic [31:0] r;
    int col;
    srst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = WORD_SIZE;
    hwdata = 32'h0;
    repeat (8) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    chk("reset mode", 32'(MODE_RST), 32'(mode));
    ahb(1'b0, REG_STATUS, 32'h0, r);
    chk("reset status", 32'h0, r);
    ahb(1'b0, 8'h10, 32'h0, r);
    chk("unmapped", 32'h0, r);
    chk("hresp", 32'h0, 32'(hresp));
    op(SBM_ACT, 2'h0, 13'h1);
    op(SBM_ACT, 2'h1, 13'h2);
    chk("banks open", 32'h3, 32'(bank_open));
    op(SBM_PRE, 2'h1, 13'h0);
    for (int c = 0; c < 10; c++) begin
      col = c < 8 ? c : c + 1014;
      ahb(1'b1, REG_WDATA, 32'(dat(col)), r);
      op(SBM_WR, 2'h0, 13'(col));
    end
    burst(10'h021, 1, 2);
    burst(10'h02A, 1, 4);
    burst(10'h032, 2, 4);
    burst(10'h03B, 3, 8);
    burst(10'h023, 5, 8);
    burst(10'h038, 6, 1);
    set_mode(10'h222);
    ahb(1'b1, REG_WDATA, 32'hA4, r);
    op(SBM_WR, 2'h0, 13'h4);
    beats.delete();
    op(SBM_RD, 2'h0, 13'h4);
    repeat (16) @(posedge mclk);
    chk("single write", 32'hA4, 32'(beats[0]));
    chk("neighbour kept", 32'(dat(5)), 32'(beats[1]));
    ahb(1'b0, REG_RDATA, 32'h0, r);
    chk("read data", 32'(dat(7)), r);
    ahb(1'b0, REG_WDATA, 32'h0, r);
    chk("write data", 32'hA4, r);
    set_mode(10'h037);
    beats.delete();
    op(SBM_RD, 2'h0, 13'h3FE);
    repeat (6) @(posedge mclk);
    chk("burst busy", 32'h1, 32'(burst_busy));
    op(SBM_BST, 2'h0, 13'h0);
    repeat (8) @(posedge mclk);
    chk("page wrap", 32'h2E2F30, {8'h0, beats[0], beats[1], beats[2]});
    chk("page stop", 32'h0, 32'(link.dq_d_oe));
    chk("burst ended", 32'h0, 32'(burst_busy));
    op(SBM_LMR, 2'h0, 13'h021);
    refused("load with bank open");
    op(SBM_ACT, 2'h0, 13'h2);
    refused("activate open bank");
    op(SBM_RD, 2'h2, 13'h0);
    refused("read closed bank");
    op(SBM_PRE, 2'h0, 13'h0);
    op(SBM_LMR, 2'h0, 13'h024);
    refused("reserved length");
    chk("mode kept", 32'h037, 32'(mode));
    chk("mode reserved", 32'h0, 32'(mode_reserved));
    summarize();
  end
endmodule // sdram_burst_mode_and_activation_bench
`default_nettype wire
